// ==== inc/ana_pkg.sv ====
// Constants, field positions and types for the auto-negotiation ability bank.
package ana_pkg;
	// Management port and field widths.
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int TECH_W = 8;
	localparam int SEL_W = 5;

	// Register offsets.
	localparam logic [ADDR_W-1:0] ADDR_ADVERT = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_PARTNER = 5'h05;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 5'h11;

	// Bit positions shared by the local and the partner ability words.
	localparam int BIT_NP = 15;
	localparam int BIT_ACK = 14;
	localparam int BIT_RF = 13;
	localparam int TECH_HI = 12;
	localparam int TECH_LO = 5;
	localparam int SEL_HI = 4;
	localparam int SEL_LO = 0;

	// Writable technology bits: 10, 8, 7, 6 and 5; 12, 11 and 9 stay clear.
	localparam logic [TECH_W-1:0] TECH_WR_MASK = 8'h2F;

	// Reset values.
	localparam logic [SEL_W-1:0] SEL_RST = 5'h01;
	localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
	localparam logic [TECH_W-1:0] TECH_PRESET_0 = 8'h01;
	localparam logic [TECH_W-1:0] TECH_PRESET_1 = 8'h02;
	localparam logic [TECH_W-1:0] TECH_PRESET_2 = 8'h0C;
	localparam logic [TECH_W-1:0] TECH_PRESET_3 = 8'h0F;

	// Status register bit positions.
	localparam int STAT_PART_AN = 0;
	localparam int STAT_PAGE_RX = 1;
	localparam int STAT_BASE_DONE = 2;
	localparam int STAT_RF = 3;

	// Configuration register bit positions and reset value.
	localparam int CFG_LEGACY = 0;
	localparam int CFG_AN_EN = 1;
	localparam logic [1:0] CFG_RST = 2'h2;

	// Page sequencing state.
	typedef enum logic [1:0] {
		ANA_PG_BASE = 2'b01,
		ANA_PG_NEXT = 2'b10
	} ana_pg_state_t;
endpackage : ana_pkg

// ==== inc/ana_page_if.sv ====
// Interface carrying received pages between the register bank and the page sequencer.
`timescale 1ns/1ps
interface ana_page_if;
	logic [15:0] page_word;
	logic page_valid;
	logic page_ok;
	logic neg_restart;
	logic page_accept;
	logic page_is_base;
	logic [15:0] next_word;

	// The register bank presents pages and reads back the sequencing result.
	modport core (
		output page_word, page_valid, page_ok, neg_restart,
		input page_accept, page_is_base, next_word
	);

	// The sequencer classifies pages as base or next page.
	modport rx (
		input page_word, page_valid, page_ok, neg_restart,
		output page_accept, page_is_base, next_word
	);
endinterface : ana_page_if

// ==== logic/ana_page_rx.sv ====
// Page sequencer: accepts checked pages and tells base page from next pages.
`timescale 1ns/1ps
module ana_page_rx (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	ana_page_if.rx pg
);
	import ana_pkg::*;

	ana_pg_state_t state;
	ana_pg_state_t next_state;

	// A page counts only once its integrity check has passed.
	assign pg.page_accept = pg.page_valid & pg.page_ok;
	assign pg.page_is_base = (state == ANA_PG_BASE);

	// First accepted page is the base page, all later ones are next pages.
	always_comb begin
		next_state = state;
		case (state)
			ANA_PG_BASE: begin
				if (pg.page_accept) begin
					next_state = ANA_PG_NEXT;
				end
			end
			ANA_PG_NEXT: begin
				next_state = ANA_PG_NEXT;
			end
			default: begin
				next_state = ANA_PG_BASE;
			end
		endcase
		if (pg.neg_restart) begin
			next_state = ANA_PG_BASE;
		end
	end

	// State register; a restart begins a new negotiation.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state <= ANA_PG_BASE;
		end else begin
			state <= next_state;
		end
	end

	// Holds the most recent next page for software.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || pg.neg_restart) begin
			pg.next_word <= WORD_RST;
		end else if (pg.page_accept && state == ANA_PG_NEXT) begin
			pg.next_word <= pg.page_word;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	a_base_then_next: assert property (
		pg.page_accept && state == ANA_PG_BASE && !pg.neg_restart
		|=> !pg.page_is_base)
		else $error("Second page still classified as base page.");

	a_next_word_take: assert property (
		pg.page_accept && !pg.page_is_base && !pg.neg_restart
		|=> pg.next_word == $past(pg.page_word))
		else $error("Next page word not captured.");
endmodule : ana_page_rx

// ==== logic/ana_regs.sv ====
// Auto-negotiation advertisement and partner ability register bank.
// Summary of operation
// - Next-page advert bit 15 writable, resets 0, enables next-page exchange.
// - Legacy compatibility mode disables next-page bit and ignores writes to it.
// - Acknowledge bit 14 set by device on consistent partner data; resets 0.
// - Remote-fault bit 13 writable, resets 0, advertised to partner.
// - Technology bits 10 and 8:5 writable, reset from preset pins, advertised.
// - Technology bit map: 10 pause, 9 T4, 8/7 TX FD/HD, 6/5 10T.
// - 100BASE-T4 bit 9 cannot be set and stays clear.
// - Selector bits 4:0 writable, reset to 00001 for 802.3.
// - Partner word bit 15 shows partner next-page ability; resets 0.
// - Partner word bit 14 shows partner acknowledge; resets 0.
// - Partner remote fault with negotiation enabled sets remote-fault status.
// - Partner technology bits 12:5 read-only, same map, reset zero.
// - Partner selector bits 4:0 read-only, reset zero.
// - Page-received flag rises when a checked page has arrived.
// - First page is base page, later pages are next pages.
// - Page-received flag clears itself without a software write.
// - Partner-capable flag set when partner negotiation ability is seen.
`timescale 1ns/1ps
module ana_regs (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [ana_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [ana_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [ana_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic [1:0] advert_preset_pins_in,
	input wire logic [ana_pkg::DATA_W-1:0] rx_page_in,
	input wire logic rx_page_valid_in,
	input wire logic rx_page_ok_in,
	input wire logic rx_consistent_in,
	input wire logic partner_an_detect_in,
	input wire logic neg_restart_in,
	output logic [ana_pkg::DATA_W-1:0] tx_advert_out,
	output logic [ana_pkg::DATA_W-1:0] next_page_rx_out,
	output logic page_received_out,
	output logic partner_an_able_out,
	output logic remote_fault_status_out
);
	import ana_pkg::*;

	// Local advertisement fields.
	logic adv_np;
	logic adv_ack;
	logic adv_rf;
	logic [TECH_W-1:0] adv_tech;
	logic [SEL_W-1:0] adv_sel;

	// Captured partner base page, flags and configuration.
	logic [DATA_W-1:0] partner_word;
	logic page_rx;
	logic partner_an;
	logic base_done;
	logic cfg_legacy;
	logic cfg_an_en;

	// Decoded strobes and composed views.
	logic wr_advert;
	logic wr_config;
	logic rd_status;
	logic [DATA_W-1:0] advert_view;
	logic [DATA_W-1:0] status_view;
	logic [DATA_W-1:0] config_view;
	logic [DATA_W-1:0] next_rdata;
	logic [TECH_W-1:0] tech_preset;
	logic rf_status;

	ana_page_if pg ();

	ana_page_rx u_page_rx (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.pg(pg)
	);

	// Received pages pass to the sequencer untouched.
	assign pg.page_word = rx_page_in;
	assign pg.page_valid = rx_page_valid_in;
	assign pg.page_ok = rx_page_ok_in;
	assign pg.neg_restart = neg_restart_in;

	// Write strobe decode for the writable registers.
	always_comb begin
		wr_advert = 1'b0;
		wr_config = 1'b0;
		if (reg_wr_in && reg_addr_in == ADDR_ADVERT) begin
			wr_advert = 1'b1;
		end else if (reg_wr_in && reg_addr_in == ADDR_CONFIG) begin
			wr_config = 1'b1;
		end
	end

	assign rd_status = reg_rd_in && (reg_addr_in == ADDR_STATUS);

	// Technology preset chosen by the strap pins.
	always_comb begin
		case (advert_preset_pins_in)
			2'b00: tech_preset = TECH_PRESET_0;
			2'b01: tech_preset = TECH_PRESET_1;
			2'b10: tech_preset = TECH_PRESET_2;
			default: tech_preset = TECH_PRESET_3;
		endcase
	end

	// Configuration: legacy compatibility mode and negotiation enable.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cfg_legacy <= CFG_RST[CFG_LEGACY];
			cfg_an_en <= CFG_RST[CFG_AN_EN];
		end else if (wr_config) begin
			cfg_legacy <= reg_wdata_in[CFG_LEGACY];
			cfg_an_en <= reg_wdata_in[CFG_AN_EN];
		end
	end

	// Next-page enable; frozen while legacy mode is on.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			adv_np <= 1'b0;
		end else if (wr_advert && !cfg_legacy) begin
			adv_np <= reg_wdata_in[BIT_NP];
		end
	end

	// Acknowledge follows consistent reception within one negotiation.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			adv_ack <= 1'b0;
		end else if (rx_consistent_in) begin
			adv_ack <= 1'b1;
		end else if (neg_restart_in) begin
			adv_ack <= 1'b0;
		end
	end

	// Remote fault, technology field and selector written by software.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			adv_rf <= 1'b0;
			adv_tech <= tech_preset & TECH_WR_MASK;
			adv_sel <= SEL_RST;
		end else if (wr_advert) begin
			adv_rf <= reg_wdata_in[BIT_RF];
			// Bits 12, 11 and 9 are masked so they never set.
			adv_tech <= reg_wdata_in[TECH_HI:TECH_LO] & TECH_WR_MASK;
			adv_sel <= reg_wdata_in[SEL_HI:SEL_LO];
		end
	end

	// The word the device sends; next page is suppressed in legacy mode.
	always_comb begin
		advert_view = WORD_RST;
		advert_view[BIT_NP] = adv_np & ~cfg_legacy;
		advert_view[BIT_ACK] = adv_ack;
		advert_view[BIT_RF] = adv_rf;
		advert_view[TECH_HI:TECH_LO] = adv_tech;
		advert_view[SEL_HI:SEL_LO] = adv_sel;
	end

	// Advertised page register toward the negotiation logic.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			tx_advert_out <= WORD_RST;
		end else begin
			tx_advert_out <= advert_view;
		end
	end

	// Partner ability word is loaded only from a checked base page.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			partner_word <= WORD_RST;
		end else if (pg.page_accept && pg.page_is_base) begin
			partner_word <= rx_page_in;
		end
	end

	// Remembers that the base page of this negotiation has arrived.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			base_done <= 1'b0;
		end else if (pg.page_accept && pg.page_is_base) begin
			base_done <= 1'b1;
		end else if (neg_restart_in) begin
			base_done <= 1'b0;
		end
	end

	// Page-received flag: a new page wins over the clear on status read.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			page_rx <= 1'b0;
		end else if (pg.page_accept) begin
			page_rx <= 1'b1;
		end else if (rd_status) begin
			page_rx <= 1'b0;
		end
	end

	// Partner negotiation capability; detection wins over a restart.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			partner_an <= 1'b0;
		end else if (partner_an_detect_in) begin
			partner_an <= 1'b1;
		end else if (neg_restart_in) begin
			partner_an <= 1'b0;
		end
	end

	// Far-end fault is reported only while negotiation is enabled.
	assign rf_status = partner_word[BIT_RF] & cfg_an_en;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			remote_fault_status_out <= 1'b0;
		end else begin
			remote_fault_status_out <= rf_status;
		end
	end

	// Status and configuration views.
	always_comb begin
		status_view = WORD_RST;
		status_view[STAT_PART_AN] = partner_an;
		status_view[STAT_PAGE_RX] = page_rx;
		status_view[STAT_BASE_DONE] = base_done;
		status_view[STAT_RF] = rf_status;
		config_view = WORD_RST;
		config_view[CFG_LEGACY] = cfg_legacy;
		config_view[CFG_AN_EN] = cfg_an_en;
	end

	// Read mux; unmapped addresses return zero.
	always_comb begin
		if (reg_addr_in == ADDR_ADVERT) begin
			next_rdata = advert_view;
		end else if (reg_addr_in == ADDR_PARTNER) begin
			next_rdata = partner_word;
		end else if (reg_addr_in == ADDR_STATUS) begin
			next_rdata = status_view;
		end else if (reg_addr_in == ADDR_CONFIG) begin
			next_rdata = config_view;
		end else begin
			next_rdata = WORD_RST;
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			reg_rdata_out <= WORD_RST;
		end else if (reg_rd_in) begin
			reg_rdata_out <= next_rdata;
		end else begin
			reg_rdata_out <= WORD_RST;
		end
	end

	// Flag and next-page outputs.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			page_received_out <= 1'b0;
			partner_an_able_out <= 1'b0;
			next_page_rx_out <= WORD_RST;
		end else begin
			page_received_out <= page_rx;
			partner_an_able_out <= partner_an;
			next_page_rx_out <= pg.next_word;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence s_advert_write;
		wr_advert && !cfg_legacy;
	endsequence

	sequence s_status_clear;
		rd_status && !pg.page_accept;
	endsequence

	sequence s_base_page;
		pg.page_accept && pg.page_is_base;
	endsequence

	a_np_write_taken: assert property (
		s_advert_write |=> adv_np == $past(reg_wdata_in[BIT_NP]))
		else $error("Next-page bit did not take the written value.");

	a_np_legacy_lock: assert property (
		wr_advert && cfg_legacy |=> adv_np == $past(adv_np)
		##1 tx_advert_out[BIT_NP] == 1'b0)
		else $error("Next-page bit changed or shown in legacy mode.");

	a_ack_set: assert property (
		rx_consistent_in |=> adv_ack ##1 tx_advert_out[BIT_ACK])
		else $error("Acknowledge bit not raised on consistent data.");

	a_rf_advertised: assert property (
		wr_advert ##1 !wr_advert
		|=> tx_advert_out[BIT_RF] == $past(reg_wdata_in[BIT_RF], 2))
		else $error("Remote fault not advertised as written.");

	a_tech_masked: assert property (
		tx_advert_out[9] == 1'b0 && adv_tech[TECH_W-1:TECH_W-2] == 2'b00)
		else $error("T4 or reserved technology bit set.");

	a_tech_write: assert property (
		wr_advert |=> adv_tech ==
		($past(reg_wdata_in[TECH_HI:TECH_LO]) & TECH_WR_MASK))
		else $error("Technology field did not take the masked write.");

	a_sel_reset: assert property (
		$fell(rst_in) |-> adv_sel == SEL_RST && !adv_np && !adv_rf)
		else $error("Selector or control bits wrong after reset.");

	a_base_capture: assert property (
		s_base_page |=> partner_word == $past(rx_page_in))
		else $error("Base page not captured into partner word.");

	a_next_no_capture: assert property (
		pg.page_accept && !pg.page_is_base
		|=> partner_word == $past(partner_word))
		else $error("Next page overwrote partner word.");

	a_page_flag_set: assert property (
		pg.page_accept |=> page_rx ##1 page_received_out)
		else $error("Page-received flag not raised.");

	a_page_flag_clear: assert property (
		s_status_clear |=> !page_rx)
		else $error("Page-received flag did not clear itself.");

	a_partner_able: assert property (
		partner_an_detect_in |=> partner_an ##1 partner_an_able_out)
		else $error("Partner-capable flag not set.");

	a_rf_status: assert property (
		partner_word[BIT_RF] && cfg_an_en |=> remote_fault_status_out)
		else $error("Remote-fault status not reported.");

	a_read_data: assert property (
		reg_rd_in && reg_addr_in == ADDR_PARTNER
		|=> reg_rdata_out == $past(partner_word))
		else $error("Partner word read back wrongly.");
endmodule : ana_regs

// ==== verification/ana_partner_model.sv ====
// Behavioural link partner that offers received pages to the register bank.
`timescale 1ns/1ps
module ana_partner_model (
	input wire logic clk_sys_in,
	input wire logic send_in,
	input wire logic ok_in,
	input wire logic [15:0] word_in,
	output logic [15:0] page_out,
	output logic valid_out,
	output logic ok_out
);
	// Start from a known word so the idle toggling below is never unknown.
	logic [15:0] page_q = 16'h0000;
	logic valid_q = 1'b0;
	logic ok_q = 1'b0;

	// The outputs show the model's registers directly.
	assign page_out = page_q;
	assign valid_out = valid_q;
	assign ok_out = ok_q;

	// A page stands for one cycle only; between pages the word toggles.
	// The bench commands base page first, then next pages, after each restart.
	always @(posedge clk_sys_in) begin
		valid_q <= send_in;
		ok_q <= send_in & ok_in;
		page_q <= send_in ? word_in : ~page_q;
	end
endmodule : ana_partner_model

// ==== verification/test_autoneg_ability_registers.sv ====
// Self-checking bench for the auto-negotiation ability register bank.
`timescale 1ns/1ps
module test_autoneg_ability_registers;
	import ana_pkg::*;
	localparam logic [TECH_W-1:0] PRESETS [4] = '{TECH_PRESET_0,
		TECH_PRESET_1, TECH_PRESET_2, TECH_PRESET_3};
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [ADDR_W-1:0] reg_addr = 5'h00;
	logic [DATA_W-1:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] preset = 2'h0;
	logic consistent = 1'b0;
	logic detect = 1'b0;
	logic restart = 1'b0;
	logic send = 1'b0;
	logic send_ok = 1'b0;
	logic [15:0] send_word = 16'h0000;
	logic [15:0] page_word;
	logic page_valid;
	logic page_ok;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] tx_advert;
	logic [DATA_W-1:0] next_page;
	logic [DATA_W-1:0] rd_val;
	logic page_rx;
	logic an_able;
	logic rf_stat;
	int err_count = 0;
	int num_checks = 0;

	// The 125 MHz system clock.
	always #4 clk_sys_in = ~clk_sys_in;

	ana_partner_model ana_partner_model_inst (.clk_sys_in(clk_sys_in),
		.send_in(send), .ok_in(send_ok), .word_in(send_word),
		.page_out(page_word), .valid_out(page_valid), .ok_out(page_ok));

	ana_regs ana_regs_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
		.advert_preset_pins_in(preset), .rx_page_in(page_word),
		.rx_page_valid_in(page_valid), .rx_page_ok_in(page_ok),
		.rx_consistent_in(consistent), .partner_an_detect_in(detect),
		.neg_restart_in(restart), .tx_advert_out(tx_advert),
		.next_page_rx_out(next_page), .page_received_out(page_rx),
		.partner_an_able_out(an_able), .remote_fault_status_out(rf_stat));

	task automatic test_done();
		if (err_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	// Compares one value with case equality so unknowns never match.
	task automatic check(input logic [DATA_W-1:0] got,
		input logic [DATA_W-1:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask : cycles

	task automatic apply_reset(input logic [1:0] p);
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		preset <= p;
		cycles(8);
		rst_in <= 1'b0;
	endtask : apply_reset

	task automatic reg_write(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge clk_sys_in);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys_in);
		reg_wr <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic reg_read(input logic [ADDR_W-1:0] a);
		@(posedge clk_sys_in);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys_in);
		reg_rd <= 1'b0;
		#1;
		rd_val = rdata;
	endtask : reg_read

	task automatic send_page(input logic [15:0] w, input logic ok);
		@(posedge clk_sys_in);
		send <= 1'b1;
		send_ok <= ok;
		send_word <= w;
		@(posedge clk_sys_in);
		send <= 1'b0;
		cycles(4);
		#1;
	endtask : send_page

	task automatic t_reset_values();
		for (int p = 0; p < 4; p++) begin
			apply_reset(2'(p));
			reg_read(ADDR_ADVERT);
			check(rd_val, {3'b000, PRESETS[p], SEL_RST}, "advert reset");
			check(tx_advert, {3'b000, PRESETS[p], SEL_RST}, "tx reset");
			reg_read(ADDR_PARTNER);
			check(rd_val, WORD_RST, "partner reset");
		end
	endtask : t_reset_values

	task automatic t_advert_write();
		reg_write(ADDR_ADVERT, 16'hFFFF);
		reg_read(ADDR_ADVERT);
		check(rd_val, {3'b101, TECH_WR_MASK, 5'h1F}, "advert ones");
		check(tx_advert, {3'b101, TECH_WR_MASK, 5'h1F}, "tx ones");
		reg_write(ADDR_ADVERT, 16'h0000);
		reg_read(ADDR_ADVERT);
		check(rd_val, 16'h0000, "advert zero");
		reg_write(ADDR_PARTNER, 16'hFFFF);
		reg_read(ADDR_PARTNER);
		check(rd_val, WORD_RST, "partner write");
		reg_read(5'h1F);
		check(rd_val, 16'h0000, "unmapped read");
	endtask : t_advert_write

	// A write under legacy mode must not reach the stored next-page bit.
	task automatic t_legacy();
		reg_write(ADDR_ADVERT, 16'h8001);
		reg_write(ADDR_CONFIG, 16'h0003);
		reg_read(ADDR_ADVERT);
		check(rd_val, 16'h0001, "legacy hides np");
		reg_read(ADDR_CONFIG);
		check(rd_val, 16'h0003, "config read");
		reg_write(ADDR_ADVERT, 16'h0021);
		reg_write(ADDR_CONFIG, 16'h0002);
		reg_read(ADDR_ADVERT);
		check(rd_val, 16'h8021, "legacy kept np");
	endtask : t_legacy

	task automatic t_pages();
		send_page(16'h5A5A, 1'b0);
		reg_read(ADDR_PARTNER);
		check(rd_val, WORD_RST, "unchecked page");
		send_page(16'hA5E1, 1'b1);
		check({15'h0000, page_rx}, 16'h0001, "page flag");
		check({15'h0000, rf_stat}, 16'h0001, "rf status");
		reg_read(ADDR_PARTNER);
		check(rd_val, 16'hA5E1, "base page");
		reg_read(ADDR_STATUS);
		check(rd_val, 16'h000E, "status set");
		reg_read(ADDR_STATUS);
		check(rd_val, 16'h000C, "status clear");
		check({15'h0000, page_rx}, 16'h0000, "flag clear");
		send_page(16'h4C33, 1'b1);
		check(next_page, 16'h4C33, "next page");
		reg_read(ADDR_PARTNER);
		check(rd_val, 16'hA5E1, "base kept");
		reg_write(ADDR_CONFIG, 16'h0000);
		cycles(3);
		check({15'h0000, rf_stat}, 16'h0000, "rf disabled");
		reg_write(ADDR_CONFIG, 16'h0002);
	endtask : t_pages

	task automatic t_flags();
		@(posedge clk_sys_in);
		consistent <= 1'b1;
		detect <= 1'b1;
		@(posedge clk_sys_in);
		consistent <= 1'b0;
		detect <= 1'b0;
		cycles(3);
		check({15'h0000, an_able}, 16'h0001, "partner able");
		reg_read(ADDR_STATUS);
		check(rd_val, 16'h000F, "status able");
		reg_read(ADDR_ADVERT);
		check({15'h0000, rd_val[BIT_ACK]}, 16'h0001, "ack set");
		@(posedge clk_sys_in);
		restart <= 1'b1;
		@(posedge clk_sys_in);
		restart <= 1'b0;
		cycles(3);
		check({15'h0000, an_able}, 16'h0000, "able cleared");
		reg_read(ADDR_ADVERT);
		check({15'h0000, rd_val[BIT_ACK]}, 16'h0000, "ack cleared");
		send_page(16'h6421, 1'b1);
		reg_read(ADDR_PARTNER);
		check(rd_val, 16'h6421, "base again");
	endtask : t_flags

	// Main sequence; each scenario judges its own results.
	initial begin
		t_reset_values();
		t_advert_write();
		t_legacy();
		t_pages();
		t_flags();
		test_done();
	end

	// Cuts a hang short well beyond the 140 or so cycles the tests need.
	initial begin
		#400000;
		err_count++;
		test_done();
	end
endmodule : test_autoneg_ability_registers
